/* rtl/nco_cfg.svh */
// offsets, field positions, reset values and widths of the oscillator block
`ifndef NCO_CFG_SVH
`define NCO_CFG_SVH
// register byte addresses on the apb bus
`define NCO_OFS_CTRL 8'h00
`define NCO_OFS_CLKCFG 8'h04
`define NCO_OFS_ACC_LOW 8'h08
`define NCO_OFS_ACC_HIGH 8'h0C
`define NCO_OFS_ACC_UPPER 8'h10
`define NCO_OFS_STEP_LOW 8'h14
`define NCO_OFS_STEP_HIGH 8'h18
`define NCO_OFS_STEP_UPPER 8'h1C
`define NCO_OFS_IRQ 8'h20
// control register fields
`define NCO_CTRL_ON 7
`define NCO_CTRL_LEVEL 5
`define NCO_CTRL_INV 4
`define NCO_CTRL_PFM 0
// clock configuration fields
`define NCO_CLK_PWS_LSB 5
`define NCO_CLK_CKS_LSB 0
// interrupt register fields
`define NCO_IRQ_FLAG 0
`define NCO_IRQ_EN 1
`define NCO_IRQ_PGATE 2
`define NCO_IRQ_GGATE 3
// clock source codes
`define NCO_CKS_FAST 2'h0
`define NCO_CKS_SYS 2'h1
`define NCO_CKS_LC3 2'h2
// reset value of every register
`define NCO_RST_BYTE 8'h00
// accumulator width and pulse counter width
`define NCO_ACC_W 20
`define NCO_PCNT_W 7
`endif

/* rtl/nco_pkg.sv */
// types shared by the oscillator block
package nco_pkg;
  // control bits that software writes
  typedef struct packed {
    logic module_on;
    logic output_invert;
    logic pulse_frequency_select;
  } nco_ctrl_t;
  // clock configuration fields
  typedef struct packed {
    logic [2:0] pulse_width_select;
    logic [1:0] clock_source_select;
  } nco_clkcfg_t;
  // interrupt enable and gate bits
  typedef struct packed {
    logic overflow_irq_enable;
    logic peripheral_irq_gate;
    logic global_irq_gate;
  } nco_irqcfg_t;
  // candidate oscillator input clocks, arriving as plain pins
  typedef struct packed {
    logic internal_fast_osc;
    logic system_osc;
    logic logic_cell3_output;
  } nco_clk_src_t;
  // increment buffer transfer sequence
  typedef enum logic [1:0] {
    LD_IDLE,
    LD_ARMED,
    LD_SEEN1
  } nco_load_state_t;
endpackage : nco_pkg

/* rtl/nco_top.sv */
// numerically controlled oscillator with apb register access
// Behaviour
// - 20-bit accumulator visible as three bytes
// - add buffered step on each input clock edge
// - accumulator carry is the raw overflow
// - 20-bit step in three rw byte registers
// - enabled: low write loads buffers on second edge
// - disabled: step write loads buffers immediately
// - step buffers hidden from software
// - fixed duty mode toggles output per overflow
// - pulse mode: active for selected periods
// - pulse starts on next edge after overflow
// - width code selects 2 to the code periods
// - invert bit flips output, final stage
// - polarity change with irq enabled sets flag
// - control bit 5 reads output level
// - control bit 7 enables the oscillator
// - source field picks fast, system, logic cell
// - overflow sets flag; irq needs all gates
// - reset clears all registers to zero
// - keep fast oscillator running when selected, enabled
// - unimplemented bits read as zero
// - upper bytes hold bits 19-16, rest zero
`timescale 1ns/1ps
`default_nettype none
`include "nco_cfg.svh"

module nco_top (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // oscillator input clock candidates
  input wire nco_pkg::nco_clk_src_t clk_src_i,
  // oscillator results
  output logic nco_out_o,
  output logic irq_o,
  output logic fast_osc_keep_o
);
  import nco_pkg::*;

  // ****************************************
  // register state
  // ****************************************
  nco_ctrl_t ctrl; // software control bits
  nco_ctrl_t next_ctrl;
  nco_clkcfg_t clkcfg; // source and width fields
  nco_clkcfg_t next_clkcfg;
  nco_irqcfg_t irqcfg; // interrupt enables
  nco_irqcfg_t next_irqcfg;
  logic [`NCO_ACC_W-1:0] step; // visible increment
  logic [`NCO_ACC_W-1:0] next_step;
  logic flag; // sticky overflow flag
  logic next_flag;
  logic inv_d; // previous polarity, for change detection
  logic next_inv_d;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic next_irq;

  // ****************************************
  // engine state
  // ****************************************
  logic [`NCO_ACC_W-1:0] acc; // phase accumulator
  logic [`NCO_ACC_W-1:0] next_acc;
  logic [`NCO_ACC_W-1:0] inc_buf; // hidden increment buffer
  logic [`NCO_ACC_W-1:0] next_inc_buf;
  nco_load_state_t ld_state; // buffer transfer sequence
  nco_load_state_t next_ld_state;
  logic imm_load; // pending immediate load while disabled
  logic next_imm_load;
  logic raw; // output before polarity
  logic next_raw;
  logic ovf_pend; // overflow waiting for the next edge
  logic next_ovf_pend;
  logic [`NCO_PCNT_W-1:0] pcnt; // remaining pulse periods
  logic [`NCO_PCNT_W-1:0] next_pcnt;
  logic next_out;
  logic next_keep;

  // ****************************************
  // synchronisers and edge detect
  // ****************************************
  logic [2:0] src_s1; // first stage, read only by second
  logic [2:0] src_s2; // synchronised sources
  logic sel_d; // selected source one cycle ago
  logic sel_now; // selected synchronised source
  logic tick; // one-cycle pulse per input clock rising edge

  // two flops per source before any logic reads it
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      src_s1 <= 3'h0;
      src_s2 <= 3'h0;
      sel_d <= 1'b0;
    end
    else
    begin
      src_s1 <= clk_src_i;
      src_s2 <= src_s1;
      sel_d <= sel_now;
    end
  end

  // source select and rising edge detection
  always_comb
  begin
    unique case (clkcfg.clock_source_select)
      `NCO_CKS_FAST: sel_now = src_s2[2];
      `NCO_CKS_SYS: sel_now = src_s2[1];
      `NCO_CKS_LC3: sel_now = src_s2[0];
      default: sel_now = 1'b0; // reserved code gives no clock
    endcase
    tick = sel_now & ~sel_d & ctrl.module_on;
  end

  // ****************************************
  // apb decode
  // ****************************************
  logic acc_taken; // access completes this cycle
  logic wr_en;
  logic rd_hit; // address is mapped
  logic step_wr; // any step byte written
  logic low_wr; // step low byte written
  logic [2:0] acc_wr; // accumulator byte writes
  logic flag_clr; // software writes flag to zero
  logic [19:0] sum_lo;
  logic carry; // raw overflow event
  logic [7:0] wb; // written byte

  // decode of the completing transfer
  always_comb
  begin
    acc_taken = psel_i & penable_i & pready_o;
    wr_en = acc_taken & pwrite_i;
    wb = pwdata_i[7:0];
    rd_hit = paddr_i inside {`NCO_OFS_CTRL, `NCO_OFS_CLKCFG, `NCO_OFS_ACC_LOW, `NCO_OFS_ACC_HIGH,
      `NCO_OFS_ACC_UPPER, `NCO_OFS_STEP_LOW, `NCO_OFS_STEP_HIGH, `NCO_OFS_STEP_UPPER, `NCO_OFS_IRQ};
    low_wr = wr_en & (paddr_i == `NCO_OFS_STEP_LOW);
    step_wr = low_wr | (wr_en & ((paddr_i == `NCO_OFS_STEP_HIGH) | (paddr_i == `NCO_OFS_STEP_UPPER)));
    acc_wr[0] = wr_en & (paddr_i == `NCO_OFS_ACC_LOW);
    acc_wr[1] = wr_en & (paddr_i == `NCO_OFS_ACC_HIGH);
    acc_wr[2] = wr_en & (paddr_i == `NCO_OFS_ACC_UPPER);
    flag_clr = wr_en & (paddr_i == `NCO_OFS_IRQ) & ~wb[`NCO_IRQ_FLAG];
  end

  // ****************************************
  // register next values
  // ****************************************
  always_comb
  begin
    next_ctrl = ctrl;
    next_clkcfg = clkcfg;
    next_irqcfg = irqcfg;
    next_step = step;
    next_inv_d = ctrl.output_invert;
    next_pready = psel_i & penable_i & ~pready_o; // one wait state
    next_pslverr = psel_i & penable_i & ~pready_o & ~rd_hit;
    next_prdata = prdata_o;
    if (wr_en)
    begin
      unique case (paddr_i)
        `NCO_OFS_CTRL:
        begin
          next_ctrl.module_on = wb[`NCO_CTRL_ON];
          next_ctrl.output_invert = wb[`NCO_CTRL_INV];
          next_ctrl.pulse_frequency_select = wb[`NCO_CTRL_PFM];
        end
        `NCO_OFS_CLKCFG:
        begin
          next_clkcfg.pulse_width_select = wb[`NCO_CLK_PWS_LSB +: 3];
          next_clkcfg.clock_source_select = wb[`NCO_CLK_CKS_LSB +: 2];
        end
        `NCO_OFS_STEP_LOW: next_step[7:0] = wb;
        `NCO_OFS_STEP_HIGH: next_step[15:8] = wb;
        `NCO_OFS_STEP_UPPER: next_step[19:16] = wb[3:0];
        `NCO_OFS_IRQ:
        begin
          next_irqcfg.overflow_irq_enable = wb[`NCO_IRQ_EN];
          next_irqcfg.peripheral_irq_gate = wb[`NCO_IRQ_PGATE];
          next_irqcfg.global_irq_gate = wb[`NCO_IRQ_GGATE];
        end
        default: next_step = step; // accumulator and unmapped handled elsewhere
      endcase
    end
    // read data latched with the answer; hidden buffer has no address
    if (psel_i & penable_i & ~pready_o & ~pwrite_i)
    begin
      next_prdata = 32'h0000_0000;
      unique case (paddr_i)
        `NCO_OFS_CTRL:
          next_prdata[7:0] = {ctrl.module_on, 1'b0, nco_out_o, ctrl.output_invert, 3'h0,
            ctrl.pulse_frequency_select};
        `NCO_OFS_CLKCFG:
          next_prdata[7:0] = {clkcfg.pulse_width_select, 3'h0, clkcfg.clock_source_select};
        `NCO_OFS_ACC_LOW: next_prdata[7:0] = acc[7:0];
        `NCO_OFS_ACC_HIGH: next_prdata[7:0] = acc[15:8];
        `NCO_OFS_ACC_UPPER: next_prdata[3:0] = acc[19:16];
        `NCO_OFS_STEP_LOW: next_prdata[7:0] = step[7:0];
        `NCO_OFS_STEP_HIGH: next_prdata[7:0] = step[15:8];
        `NCO_OFS_STEP_UPPER: next_prdata[3:0] = step[19:16];
        `NCO_OFS_IRQ:
          next_prdata[3:0] = {irqcfg.global_irq_gate, irqcfg.peripheral_irq_gate,
            irqcfg.overflow_irq_enable, flag};
        default: next_prdata = 32'h0000_0000; // unmapped reads zero with error
      endcase
    end
    // set wins over a clear in the same cycle
    next_flag = flag & ~flag_clr;
    if (carry)
      next_flag = 1'b1;
    if ((ctrl.output_invert != inv_d) & irqcfg.overflow_irq_enable)
      next_flag = 1'b1;
    next_irq = next_flag & ctrl.module_on & irqcfg.overflow_irq_enable &
      irqcfg.peripheral_irq_gate & irqcfg.global_irq_gate;
    next_keep = ctrl.module_on & (clkcfg.clock_source_select == `NCO_CKS_FAST);
  end

  // register flops, all cleared at reset
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ctrl <= '0;
      clkcfg <= '0;
      irqcfg <= '0;
      step <= '0;
      flag <= 1'b0;
      inv_d <= 1'b0;
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      irq_o <= 1'b0;
      fast_osc_keep_o <= 1'b0;
    end
    else
    begin
      ctrl <= next_ctrl;
      clkcfg <= next_clkcfg;
      irqcfg <= next_irqcfg;
      step <= next_step;
      flag <= next_flag;
      inv_d <= next_inv_d;
      prdata_o <= next_prdata;
      pready_o <= next_pready;
      pslverr_o <= next_pslverr;
      irq_o <= next_irq;
      fast_osc_keep_o <= next_keep;
    end
  end

  // ****************************************
  // accumulator, buffer and output engine
  // ****************************************
  logic [`NCO_ACC_W:0] sum; // carry plus wrapped sum

  always_comb
  begin
    sum = {1'b0, acc} + {1'b0, inc_buf};
    sum_lo = sum[`NCO_ACC_W-1:0]; // wraps modulo 2 to the 20
    carry = tick & sum[`NCO_ACC_W];
    next_acc = acc;
    if (tick)
      next_acc = sum_lo; // disabled gives no tick, acc holds
    // software writes win over an addition in the same cycle
    if (acc_wr[0])
      next_acc[7:0] = wb;
    if (acc_wr[1])
      next_acc[15:8] = wb;
    if (acc_wr[2])
      next_acc[19:16] = wb[3:0];
    // buffer transfer: armed by low byte write while enabled
    next_ld_state = ld_state;
    next_inc_buf = inc_buf;
    next_imm_load = ~ctrl.module_on & step_wr;
    if (imm_load)
      next_inc_buf = step;
    unique case (ld_state)
      LD_IDLE:
        if (tick)
          next_ld_state = LD_IDLE;
      LD_ARMED:
        if (tick)
          next_ld_state = LD_SEEN1;
      LD_SEEN1:
        if (tick)
        begin
          next_inc_buf = step; // second edge after the write
          next_ld_state = LD_IDLE;
        end
    endcase
    if (~ctrl.module_on)
      next_ld_state = LD_IDLE;
    else if (low_wr) // high and upper expected first
      next_ld_state = LD_ARMED;
    // output stage
    next_raw = raw;
    next_pcnt = pcnt;
    next_ovf_pend = ovf_pend;
    if (~ctrl.module_on)
    begin
      next_raw = 1'b0;
      next_ovf_pend = 1'b0;
      next_pcnt = '0;
    end
    else if (~ctrl.pulse_frequency_select)
    begin
      next_ovf_pend = 1'b0;
      if (carry)
        next_raw = ~raw;
    end
    else if (tick)
    begin
      next_ovf_pend = carry;
      if (ovf_pend)
      begin
        next_raw = 1'b1;
        next_pcnt = `NCO_PCNT_W'((8'h01 << clkcfg.pulse_width_select) - 8'h01);
      end
      else if (raw & (pcnt != '0))
        next_pcnt = pcnt - `NCO_PCNT_W'(1);
      else
        next_raw = 1'b0; // count spent or no pulse: output goes low
    end
    next_out = next_raw ^ ctrl.output_invert;
  end

  // engine flops
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      acc <= '0;
      inc_buf <= '0;
      ld_state <= LD_IDLE;
      imm_load <= 1'b0;
      raw <= 1'b0;
      ovf_pend <= 1'b0;
      pcnt <= '0;
      nco_out_o <= 1'b0;
    end
    else
    begin
      acc <= next_acc;
      inc_buf <= next_inc_buf;
      ld_state <= next_ld_state;
      imm_load <= next_imm_load;
      raw <= next_raw;
      ovf_pend <= next_ovf_pend;
      pcnt <= next_pcnt;
      nco_out_o <= next_out;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence s_step_wr_off;
    !ctrl.module_on && step_wr ##1 !ctrl.module_on;
  endsequence
  sequence s_off3;
    !ctrl.module_on [*3];
  endsequence

  property p_acc_step;
    tick && (acc_wr == 3'h0) |=> acc == 20'($past(acc) + $past(inc_buf));
  endproperty
  a_acc_step: assert property (p_acc_step) else $error("accumulator did not add step");

  property p_hold_off;
    !ctrl.module_on && (acc_wr == 3'h0) |=> $stable(acc);
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("accumulator moved while disabled");

  property p_out_off;
    s_off3 |-> nco_out_o == $past(ctrl.output_invert); // output flop lags the polarity bit by one cycle
  endproperty
  a_out_off: assert property (p_out_off) else $error("output active while disabled");

  property p_fdc_toggle;
    ctrl.module_on && !ctrl.pulse_frequency_select && carry |=> raw != $past(raw);
  endproperty
  a_fdc_toggle: assert property (p_fdc_toggle) else $error("no toggle on overflow");

  property p_pf_start;
    ctrl.module_on && ctrl.pulse_frequency_select && tick && ovf_pend |=> raw && pcnt ==
      `NCO_PCNT_W'((8'h01 << $past(clkcfg.pulse_width_select)) - 8'h01);
  endproperty
  a_pf_start: assert property (p_pf_start) else $error("pulse did not start");

  property p_flag_set;
    carry |=> flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("overflow lost flag");

  property p_flag_hold;
    flag && !flag_clr |=> flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag cleared by itself");

  property p_load_off;
    s_step_wr_off |-> ##1 inc_buf == step;
  endproperty
  a_load_off: assert property (p_load_off) else $error("buffer not loaded while disabled");

endmodule : nco_top
`default_nettype wire

/* verification/nco_partner_model.sv */
// source clock model: bursts on the selected line, free toggling elsewhere
`timescale 1ns/1ps
`default_nettype none

module nco_partner_model (
  // control from the bench
  input wire logic [1:0] sel_i,
  input wire logic [7:0] count_i,
  input wire logic go_i,
  // clocks towards the oscillator
  output nco_pkg::nco_clk_src_t clk_src_o,
  output logic busy_o
);
  import nco_pkg::*;
  logic burst; // counted edges on the selected line, low between bursts
  logic free_clk; // unselected lines keep running

  // ***************
  // burst generator
  // ***************
  // each half period spans at least two core cycles
  initial
  begin
    burst = 1'b0;
    busy_o = 1'b0;
    forever
    begin
      @(posedge go_i);
      busy_o = 1'b1;
      repeat (count_i)
      begin
        #350 burst = 1'b1;
        #350 burst = 1'b0;
      end
      busy_o = 1'b0;
    end
  end

  // free running clock, unrelated to the bursts
  initial
  begin
    free_clk = 1'b0;
    forever #250 free_clk = ~free_clk;
  end

  // route the burst onto the line named by the source code
  always_comb
  begin
    clk_src_o.internal_fast_osc = (sel_i == 2'h0) ? burst : free_clk;
    clk_src_o.system_osc = (sel_i == 2'h1) ? burst : free_clk;
    clk_src_o.logic_cell3_output = (sel_i == 2'h2) ? burst : free_clk;
  end
endmodule : nco_partner_model
`default_nettype wire

/* verification/testbench.sv */
// self-checking bench for the oscillator block
`timescale 1ns/1ps
`default_nettype none
`include "nco_cfg.svh"
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("[ERR] %0t got %h expected %h", $time, got, exp); end end

module testbench;
  import nco_pkg::*;
  logic core_clk_i, reset_n_i, psel, penable, pwrite, go, busy, measuring;
  logic [7:0] paddr, cnt;
  logic [1:0] sel;
  logic [31:0] pwdata, prdata, rnd;
  logic pready, pslverr, nco_out, irq, keep;
  nco_clk_src_t clk_src;
  logic [32:0] exp_q[$]; // expected {pslverr, prdata} per read
  logic [32:0] e;
  int pq[$]; // expected pulse lengths in core cycles
  int checks, miscompares, hi_len, cyc, exp_len;
  logic [19:0] s;

  // ***************
  // design and far side
  // ***************
  nco_top i_nco_top (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .clk_src_i(clk_src),
    .nco_out_o(nco_out), .irq_o(irq), .fast_osc_keep_o(keep));
  nco_partner_model i_nco_partner_model (.sel_i(sel), .count_i(cnt), .go_i(go),
    .clk_src_o(clk_src), .busy_o(busy));

  // 10 MHz clock
  initial
  begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next

  // ***************
  // tasks
  // ***************
  task automatic close_out();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  // one apb transfer; a read notes its expected answer first
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic err);
    int k;
    if (!wr) exp_q.push_back({err, 24'h0, d});
    @(posedge core_clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge core_clk_i);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge core_clk_i);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (k >= 20)
    begin
      miscompares++;
      $display("[ERR] %0t no pready", $time);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] d);
    apb(1'b0, a, d, 1'b0);
  endtask : rd

  // 20-bit value, upper and high bytes before low
  task automatic wr20(input logic [7:0] a, input logic [19:0] v);
    wr(a + 8'h08, {4'h0, v[19:16]});
    wr(a + 8'h04, v[15:8]);
    wr(a, v[7:0]);
  endtask : wr20

  task automatic rd20(input logic [7:0] a, input logic [19:0] v);
    rd(a, v[7:0]);
    rd(a + 8'h04, v[15:8]);
    rd(a + 8'h08, {4'h0, v[19:16]});
  endtask : rd20

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask : idle

  // n edges on the selected source, then let them settle
  task automatic ticks(input logic [7:0] n);
    int k;
    cnt <= n;
    @(posedge core_clk_i);
    go <= 1'b1;
    @(posedge core_clk_i);
    go <= 1'b0;
    k = 0;
    @(posedge core_clk_i);
    while (busy === 1'b1 && k < 400)
    begin
      @(posedge core_clk_i);
      k++;
    end
    if (k >= 400)
    begin
      miscompares++;
      $display("[ERR] %0t source burst hung", $time);
    end
    idle(5);
  endtask : ticks

  // restart from a disabled block with cleared accumulator
  task automatic setup(input logic [19:0] step, input logic [7:0] clk_cfg);
    wr(`NCO_OFS_CTRL, 8'h00);
    wr20(`NCO_OFS_ACC_LOW, 20'h0);
    wr20(`NCO_OFS_STEP_LOW, step);
    wr(`NCO_OFS_CLKCFG, clk_cfg);
    sel <= clk_cfg[1:0];
  endtask : setup

  // ***************
  // output watchers
  // ***************
  // read data checked against the oldest note
  always @(posedge core_clk_i)
  begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0)
    begin
      if (exp_q.size() == 0)
        e = 33'h0;
      else
        e = exp_q.pop_front();
      `CHK(prdata, e[31:0])
      `CHK(pslverr, e[32])
    end
  end

  // pulse length measured on each falling output
  always @(posedge core_clk_i)
  begin
    if (nco_out === 1'b1)
      hi_len <= hi_len + 1;
    else
    begin
      if (hi_len != 0 && measuring === 1'b1)
      begin
        // take the note once, so that a mismatch print does not pop again
        exp_len = (pq.size() != 0) ? pq.pop_front() : -1;
        `CHK(hi_len, exp_len)
      end
      hi_len <= 0;
    end
  end

  // hang guard
  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      miscompares++;
      close_out();
    end
  end

  // ***************
  // main sequence
  // ***************
  initial
  begin
    {psel, penable, pwrite, go, measuring} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cnt = 8'h00;
    sel = 2'h3;
    rnd = 32'h2455;
    reset_n_i = 1'b0;
    idle(4);
    reset_n_i <= 1'b1;
    // reset values and the refused address
    for (int a = 0; a <= 32; a += 4)
      rd(8'(a), 8'h00);
    apb(1'b0, 8'h24, 8'h00, 1'b1);
    `CHK({nco_out, irq, keep}, 3'h0)
    $display("reset test done");
    // unimplemented bits and polarity
    wr(`NCO_OFS_CLKCFG, 8'hFF);
    rd(`NCO_OFS_CLKCFG, 8'hE3);
    wr(`NCO_OFS_STEP_UPPER, 8'hFF);
    rd(`NCO_OFS_STEP_UPPER, 8'h0F);
    wr(`NCO_OFS_ACC_UPPER, 8'hFF);
    rd(`NCO_OFS_ACC_UPPER, 8'h0F);
    wr(`NCO_OFS_CTRL, 8'h6E);
    rd(`NCO_OFS_CTRL, 8'h00);
    wr(`NCO_OFS_CTRL, 8'h10);
    idle(3);
    `CHK(nco_out, 1'b1)
    rd(`NCO_OFS_CTRL, 8'h30);
    rd(`NCO_OFS_IRQ, 8'h00);
    wr(`NCO_OFS_IRQ, 8'h02);
    wr(`NCO_OFS_CTRL, 8'h00);
    idle(3);
    rd(`NCO_OFS_IRQ, 8'h03);
    wr(`NCO_OFS_IRQ, 8'h00);
    rd(`NCO_OFS_IRQ, 8'h00);
    $display("register test done");
    // every source code, disabled step writes load at once
    for (int c = 0; c < 4; c++)
    begin
      rnd = lfsr_next(rnd);
      s = rnd[19:0] & 20'h1FFFF;
      setup(s, 8'(c));
      wr(`NCO_OFS_CTRL, 8'h80);
      idle(3);
      `CHK(keep, logic'(c == 0))
      ticks(8'd5);
      rd20(`NCO_OFS_ACC_LOW, (c == 3) ? 20'h0 : 20'(s + s + s + s + s));
      wr(`NCO_OFS_CTRL, 8'h00);
      ticks(8'd3);
      rd20(`NCO_OFS_ACC_LOW, (c == 3) ? 20'h0 : 20'(s + s + s + s + s));
      `CHK(keep, 1'b0)
    end
    $display("source test done");
    // overflow toggles, flag and gated request
    setup(20'h40000, 8'h01);
    wr(`NCO_OFS_IRQ, 8'h0E);
    wr(`NCO_OFS_CTRL, 8'h80);
    ticks(8'd4);
    `CHK(nco_out, 1'b1)
    rd(`NCO_OFS_IRQ, 8'h0F);
    `CHK(irq, 1'b1)
    wr(`NCO_OFS_IRQ, 8'h0F);
    rd(`NCO_OFS_IRQ, 8'h0F);
    wr(`NCO_OFS_IRQ, 8'h0E);
    idle(3);
    `CHK(irq, 1'b0)
    ticks(8'd4);
    `CHK(nco_out, 1'b0)
    `CHK(irq, 1'b1)
    wr(`NCO_OFS_IRQ, 8'h06);
    idle(3);
    `CHK(irq, 1'b0)
    rd20(`NCO_OFS_ACC_LOW, 20'h0);
    // enabled step change waits for the second source edge
    wr20(`NCO_OFS_STEP_LOW, 20'h00123);
    ticks(8'd1);
    rd20(`NCO_OFS_ACC_LOW, 20'h40000);
    // second edge still adds the old step and loads the new one, third adds it
    ticks(8'd2);
    rd20(`NCO_OFS_ACC_LOW, 20'h80123);
    $display("overflow test done");
    // pulse widths kept below the overflow period of 16 edges
    for (int w = 0; w < 4; w++)
    begin
      setup(20'h10000, 8'((w << 5) | 1));
      wr(`NCO_OFS_CTRL, 8'h81);
      measuring = 1'b1;
      pq.push_back(7 << w);
      ticks(8'd16);
      `CHK(nco_out, 1'b0)
      ticks(8'((1 << w) + 2));
      measuring = 1'b0;
    end
    `CHK(pq.size(), 0)
    $display("pulse test done");
    // a second reset in mid-run clears every register again
    @(posedge core_clk_i);
    reset_n_i <= 1'b0;
    idle(2);
    reset_n_i <= 1'b1;
    for (int a = 0; a <= 32; a += 4)
      rd(8'(a), 8'h00);
    `CHK({nco_out, irq, keep}, 3'h0)
    $display("mid-run reset test done");
    close_out();
  end
endmodule : testbench
`default_nettype wire
